// ===== core/fcm_mailbox.v
// shared-RAM command mailbox and sequencer of the floppy controller
`timescale 1ns/1ps
//
// How it works
// - a set top bit in the trigger byte marks a posted command
// - the first eight command block bytes are copied before acting
// - with interrupts pending only clear-interrupt-status and go away may run
// - commands split into interrupting ones, which lock the host out
// - after classifying, clear trigger, check parameters, report error code
// - drive enable and disable clear trigger after status is written
// - interrupt request line is high while an interrupt is pending
// - drive interrupt disable is code 57, mask byte 1, drive 00/80
// - rom wait parks head, clears trigger, waits for 69 then 96
// - after the release sequence the controller cold starts
// - go away abandons any operation but a locked disk operation and halts until the next reset
// - side, track, speed, retry, confirm and sector ranges are hex
// - read and write seek implicitly and return status, and retries only on success
// - a 524-byte data buffer sits in shared RAM
// - host cannot interrupt a disk operation until status is ready
// - sequencer is always waiting, polling drives or executing
// - shared RAM is cleared at start, host parameter area untouched
// - clamp only for a drive whose interrupts are enabled
// - format overwrites tracks and reports unformattable sectors
`include "fcm_regs.vh"

module fcm_mailbox (
  input  wire        clk,
  input  wire        srst,
  input  wire [9:0]  host_addr,
  input  wire        host_wr,
  input  wire [7:0]  host_wdata,
  input  wire        host_rd,
  output reg  [7:0]  host_rdata_reg,
  output reg         host_locked_reg,
  output reg         disk_interrupt_request_reg,
  output reg         controller_busy_flag_reg,
  output reg  [1:0]  seq_phase_reg,
  output reg         op_start_reg,
  output reg         op_abort_reg,
  output reg  [7:0]  op_func_reg,
  output reg         op_drive_reg,
  output reg         op_side_reg,
  output reg  [7:0]  op_track_reg,
  output reg  [7:0]  op_sector_reg,
  input  wire        op_done,
  input  wire [7:0]  op_error,
  input  wire [7:0]  op_retries,
  input  wire [1:0]  disk_present
);

  // ---------------------------------------------------------------
  // states and phases
  // ---------------------------------------------------------------
  localparam [3:0] ST_INIT  = 4'h0;
  localparam [3:0] ST_IDLE  = 4'h1;
  localparam [3:0] ST_POLL  = 4'h2;
  localparam [3:0] ST_COPY  = 4'h3;
  localparam [3:0] ST_CHECK = 4'h4;
  localparam [3:0] ST_CLEAR = 4'h5;
  localparam [3:0] ST_VALID = 4'h6;
  localparam [3:0] ST_EXEC  = 4'h7;
  localparam [3:0] ST_WAIT  = 4'h8;
  localparam [3:0] ST_DONE  = 4'h9;
  localparam [3:0] ST_FIN   = 4'ha;
  localparam [3:0] ST_ROMW  = 4'hb;
  localparam [3:0] ST_HALT  = 4'hc;
  localparam [1:0] PH_WAIT  = 2'h0;
  localparam [1:0] PH_POLL  = 2'h1;
  localparam [1:0] PH_EXEC  = 2'h2;

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  reg [7:0] ram [0:1023];
  reg [7:0] icopy [0:7];
  reg [3:0] state_reg;
  reg [9:0] init_idx_reg;
  reg [2:0] copy_idx_reg;
  reg [7:0] err_reg;
  reg       intr_class_reg;
  reg       defer_clear_reg;
  reg [1:0] drv_en_reg;
  reg [1:0] pend_reg;
  reg [1:0] present_reg;
  reg       seen_first_reg;
  reg       dev_we;
  reg [9:0] dev_addr;
  reg [7:0] dev_wdata;
  reg [1:0] pend_set;
  reg [1:0] pend_clr;
  reg [1:0] pend_next;

  // largest sector number of a track zone
  function [7:0] max_sector;
    input [7:0] trk;
    begin
      if (trk <= 8'h03)      max_sector = 8'h15;
      else if (trk <= 8'h0a) max_sector = 8'h14;
      else if (trk <= 8'h10) max_sector = 8'h13;
      else if (trk <= 8'h16) max_sector = 8'h12;
      else if (trk <= 8'h1c) max_sector = 8'h11;
      else if (trk <= 8'h22) max_sector = 8'h10;
      else if (trk <= 8'h29) max_sector = 8'h0f;
      else                   max_sector = 8'h0e;
    end
  endfunction

  // true for a drive byte naming one of the two drives
  function drive_ok;
    input [7:0] drv;
    begin
      drive_ok = (drv == `FCM_DRV_TOP) || (drv == `FCM_DRV_OTHER);
    end
  endfunction

  // ---------------------------------------------------------------
  // decoded views
  // ---------------------------------------------------------------
  wire [7:0] trig     = ram[`FCM_OFS_TRIGGER];
  wire [7:0] cmd_code = icopy[0];
  wire [7:0] cmd_fn   = icopy[1];
  wire       cmd_drv  = icopy[2][7];
  wire       host_wok = host_wr && !host_locked_reg && !dev_we;
  wire       trg_wr   = host_wok && (host_addr == `FCM_OFS_TRIGGER);
  wire       posted   = trig[7] || (trig == `FCM_TRG_DRV_DIS);
  wire       go_away  = trg_wr && (host_wdata == `FCM_TRG_GO_AWAY) &&
                        (state_reg != ST_INIT) && (state_reg != ST_HALT);
  wire       in_param = (init_idx_reg >= `FCM_OFS_HOST_LO) &&
                        (init_idx_reg <= `FCM_OFS_HOST_HI);

  // device-side RAM writes; the host parameter area is never touched
  always @* begin
    dev_we = 1'b0;
    dev_addr = `FCM_OFS_TRIGGER;
    dev_wdata = 8'h00;
    case (state_reg)
      ST_INIT: begin
        dev_we = !in_param;
        dev_addr = init_idx_reg;
      end
      ST_CLEAR: begin
        dev_we = !defer_clear_reg;
      end
      ST_DONE: begin
        dev_we = 1'b1;
        dev_addr = `FCM_OFS_ERROR;
        dev_wdata = err_reg;
      end
      ST_FIN: begin
        if (defer_clear_reg) begin
          dev_we = 1'b1;
        end else if (cmd_code == `FCM_TRG_DISK_OP && err_reg == `FCM_ERR_NONE &&
                     (cmd_fn == `FCM_FN_READ || cmd_fn == `FCM_FN_WRITE)) begin
          dev_we = 1'b1;
          dev_addr = `FCM_OFS_RETRY;
          dev_wdata = op_retries;
        end
      end
      default: begin
        dev_we = 1'b0;
      end
    endcase
  end

  // shared RAM: device writes win, host writes go through when free
  always @(posedge clk) begin
    if (dev_we) begin
      ram[dev_addr] <= dev_wdata;
    end else if (host_wok) begin
      ram[host_addr] <= host_wdata;
    end
  end

  // host read port, refused reads return zero
  always @(posedge clk) begin
    if (srst) begin
      host_rdata_reg <= 8'h00;
    end else if (host_rd && !host_locked_reg) begin
      host_rdata_reg <= ram[host_addr];
    end else begin
      host_rdata_reg <= 8'h00;
    end
  end

  // interrupt pending bits, a set wins over a clear in the same cycle
  always @* begin
    pend_set = 2'b00;
    pend_clr = 2'b00;
    if (state_reg == ST_POLL) begin
      pend_set = disk_present & ~present_reg & drv_en_reg;
    end
    if (state_reg == ST_WAIT && op_done && cmd_code == `FCM_TRG_DISK_OP) begin
      pend_set[cmd_drv] = 1'b1;
    end
    if (state_reg == ST_EXEC && cmd_code == `FCM_TRG_CLR_INT) begin
      pend_clr = cmd_fn[1:0];
    end
    pend_next = (pend_reg & ~pend_clr) | pend_set;
  end

  // ---------------------------------------------------------------
  // command sequencer
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      state_reg <= ST_INIT;
      init_idx_reg <= 10'h000;
      copy_idx_reg <= 3'h0;
      err_reg <= `FCM_ERR_NONE;
      intr_class_reg <= 1'b0;
      defer_clear_reg <= 1'b0;
      drv_en_reg <= 2'b00;
      pend_reg <= 2'b00;
      present_reg <= 2'b00;
      seen_first_reg <= 1'b0;
      host_locked_reg <= 1'b0;
      controller_busy_flag_reg <= 1'b0;
      op_start_reg <= 1'b0;
      op_abort_reg <= 1'b0;
      op_func_reg <= 8'h00;
      op_drive_reg <= 1'b0;
      op_side_reg <= 1'b0;
      op_track_reg <= 8'h00;
      op_sector_reg <= 8'h00;
    end else begin
      op_start_reg <= 1'b0;
      op_abort_reg <= 1'b0;
      pend_reg <= pend_next;
      if (go_away) begin
        op_abort_reg <= 1'b1;
        host_locked_reg <= 1'b0;
        controller_busy_flag_reg <= 1'b0;
        state_reg <= ST_HALT;
      end else begin
        case (state_reg)
          ST_INIT: begin
            controller_busy_flag_reg <= 1'b0;
            init_idx_reg <= init_idx_reg + 10'h001;
            if (init_idx_reg == `FCM_OFS_BUF_END) begin
              state_reg <= ST_IDLE;
            end
          end
          ST_IDLE: begin
            controller_busy_flag_reg <= 1'b1;
            if (posted) begin
              controller_busy_flag_reg <= 1'b0;
              copy_idx_reg <= 3'h0;
              state_reg <= ST_COPY;
            end else begin
              state_reg <= ST_POLL;
            end
          end
          ST_POLL: begin
            present_reg <= disk_present;
            state_reg <= ST_IDLE;
          end
          ST_COPY: begin
            icopy[copy_idx_reg] <= ram[{7'h00, copy_idx_reg}];
            copy_idx_reg <= copy_idx_reg + 3'h1;
            if (copy_idx_reg == `FCM_COPY_LAST) begin
              state_reg <= ST_CHECK;
            end
          end
          ST_CHECK: begin
            err_reg <= `FCM_ERR_NONE;
            intr_class_reg <= (cmd_code == `FCM_TRG_DISK_OP);
            host_locked_reg <= (cmd_code == `FCM_TRG_DISK_OP);
            defer_clear_reg <= (cmd_code == `FCM_TRG_DRV_EN) ||
                               (cmd_code == `FCM_TRG_DRV_DIS) ||
                               (cmd_code == `FCM_TRG_ROM_WAIT);
            if (|pend_reg && cmd_code != `FCM_TRG_CLR_INT) begin
              err_reg <= `FCM_ERR_INT_PEND;
              host_locked_reg <= 1'b0;
              state_reg <= ST_DONE;
            end else begin
              state_reg <= ST_CLEAR;
            end
          end
          ST_CLEAR: begin
            state_reg <= ST_VALID;
          end
          ST_VALID: begin
            state_reg <= ST_EXEC;
            case (cmd_code)
              `FCM_TRG_DISK_OP: begin
                if (cmd_fn != `FCM_FN_READ && cmd_fn != `FCM_FN_WRITE &&
                    cmd_fn != `FCM_FN_UNCLAMP && cmd_fn != `FCM_FN_FORMAT &&
                    cmd_fn != `FCM_FN_SEEK && cmd_fn != `FCM_FN_CLAMP) begin
                  err_reg <= `FCM_ERR_CMD;
                end else if (!drive_ok(icopy[2])) begin
                  err_reg <= `FCM_ERR_DRIVE;
                end else if (icopy[3] > `FCM_SIDE_MAX) begin
                  err_reg <= `FCM_ERR_SIDE;
                end else if (icopy[5] > `FCM_TRACK_MAX) begin
                  err_reg <= `FCM_ERR_TRACK;
                end else if (icopy[4] > max_sector(icopy[5])) begin
                  err_reg <= `FCM_ERR_SECTOR;
                end else if (cmd_fn == `FCM_FN_FORMAT &&
                             icopy[7] != `FCM_CONFIRM_VAL) begin
                  err_reg <= `FCM_ERR_CONFIRM;
                end else if (cmd_fn == `FCM_FN_CLAMP && !drv_en_reg[cmd_drv]) begin
                  err_reg <= `FCM_ERR_NOT_EN;
                end
              end
              `FCM_TRG_CLR_INT: begin
                if (cmd_fn[1:0] == 2'b00) begin
                  err_reg <= `FCM_ERR_MASK;
                end
              end
              `FCM_TRG_DRV_EN, `FCM_TRG_DRV_DIS: begin
                if (!drive_ok(icopy[2])) begin
                  err_reg <= `FCM_ERR_DRIVE;
                end
              end
              `FCM_TRG_ROM_WAIT, `FCM_TRG_GO_AWAY: begin
                err_reg <= `FCM_ERR_NONE;
              end
              default: begin
                err_reg <= `FCM_ERR_CMD;
              end
            endcase
          end
          ST_EXEC: begin
            state_reg <= ST_DONE;
            if (err_reg != `FCM_ERR_NONE) begin
              host_locked_reg <= 1'b0;
            end else begin
              case (cmd_code)
                `FCM_TRG_DISK_OP, `FCM_TRG_ROM_WAIT: begin
                  op_start_reg <= 1'b1;
                  op_func_reg <= (cmd_code == `FCM_TRG_ROM_WAIT) ? `FCM_FN_PARK : cmd_fn;
                  op_drive_reg <= cmd_drv;
                  op_side_reg <= icopy[3][0];
                  op_track_reg <= icopy[5];
                  op_sector_reg <= icopy[4];
                  state_reg <= ST_WAIT;
                end
                `FCM_TRG_DRV_EN: begin
                  drv_en_reg[cmd_drv] <= 1'b1;
                end
                `FCM_TRG_DRV_DIS: begin
                  drv_en_reg[cmd_drv] <= 1'b0;
                end
                `FCM_TRG_GO_AWAY: begin
                  op_abort_reg <= 1'b1;
                  state_reg <= ST_HALT;
                end
                default: begin
                  state_reg <= ST_DONE;
                end
              endcase
            end
          end
          ST_WAIT: begin
            if (op_done) begin
              err_reg <= op_error;
              state_reg <= ST_DONE;
            end
          end
          ST_DONE: begin
            state_reg <= ST_FIN;
          end
          ST_FIN: begin
            host_locked_reg <= 1'b0;
            if (cmd_code == `FCM_TRG_ROM_WAIT && err_reg == `FCM_ERR_NONE) begin
              seen_first_reg <= 1'b0;
              state_reg <= ST_ROMW;
            end else begin
              controller_busy_flag_reg <= 1'b1;
              state_reg <= ST_IDLE;
            end
          end
          ST_ROMW: begin
            if (trg_wr) begin
              if (seen_first_reg && host_wdata == `FCM_REL_SECOND) begin
                init_idx_reg <= 10'h000;
                drv_en_reg <= 2'b00;
                pend_reg <= 2'b00;
                present_reg <= 2'b00;
                state_reg <= ST_INIT;
              end else begin
                seen_first_reg <= (host_wdata == `FCM_REL_FIRST);
              end
            end
          end
          ST_HALT: begin
            controller_busy_flag_reg <= 1'b0;
          end
          default: begin
            state_reg <= ST_INIT;
          end
        endcase
      end
    end
  end

  // clear-on-commit for deferred trigger and rom wait trigger
  // (the trigger byte itself is written through dev_we above)

  // interrupt line and sequencer phase
  always @(posedge clk) begin
    if (srst) begin
      disk_interrupt_request_reg <= 1'b0;
      seq_phase_reg <= PH_WAIT;
    end else begin
      disk_interrupt_request_reg <= |pend_next;
      case (state_reg)
        // the finish step hands back to waiting, so the phase drops with the busy flag rising
        ST_IDLE, ST_INIT, ST_ROMW, ST_HALT, ST_FIN: seq_phase_reg <= PH_WAIT;
        ST_POLL: seq_phase_reg <= PH_POLL;
        default: seq_phase_reg <= PH_EXEC;
      endcase
    end
  end

endmodule // fcm_mailbox

// ===== core/fcm_regs.vh
// register offsets, codes and constants of the floppy command mailbox
`ifndef FCM_REGS_VH
`define FCM_REGS_VH
// ---------------------------------------------------------------
// shared command block byte offsets
// ---------------------------------------------------------------
`define FCM_OFS_TRIGGER    10'h000
`define FCM_OFS_PARAM      10'h001
`define FCM_OFS_DRIVE      10'h002
`define FCM_OFS_SIDE       10'h003
`define FCM_OFS_SECTOR     10'h004
`define FCM_OFS_TRACK      10'h005
`define FCM_OFS_SPEED      10'h006
`define FCM_OFS_CONFIRM    10'h007
`define FCM_OFS_ERROR      10'h008
`define FCM_OFS_DISK_TYPE  10'h009
`define FCM_OFS_RETRY      10'h02c
`define FCM_OFS_DHEAD_SLIP 10'h05b
`define FCM_OFS_DTAIL_SLIP 10'h05c
`define FCM_OFS_DSUM_ERR   10'h05d
`define FCM_OFS_IHEAD_SLIP 10'h05e
`define FCM_OFS_ITAIL_SLIP 10'h05f
`define FCM_OFS_WRONG_SEC  10'h060
`define FCM_OFS_WRONG_TRK  10'h061
`define FCM_OFS_HSUM_ERR   10'h062
`define FCM_OFS_USER_SUM0  10'h07e
`define FCM_OFS_USER_SUM1  10'h07f
`define FCM_OFS_USER_SUM2  10'h080
`define FCM_OFS_HOST_LO    10'h180
`define FCM_OFS_HOST_HI    10'h1f3
`define FCM_OFS_BUF_BEGIN  10'h1f4
`define FCM_OFS_BUF_END    10'h3ff
`define FCM_BUF_BYTES      11'h20c
`define FCM_COPY_LAST      3'h7
// ---------------------------------------------------------------
// trigger codes, disk functions and field values
// ---------------------------------------------------------------
`define FCM_TRG_DISK_OP    8'h81
`define FCM_TRG_CALL       8'h84
`define FCM_TRG_CLR_INT    8'h85
`define FCM_TRG_DRV_EN     8'h86
`define FCM_TRG_DRV_DIS    8'h57
`define FCM_TRG_ROM_WAIT   8'h88
`define FCM_TRG_GO_AWAY    8'h89
`define FCM_REL_FIRST      8'h69
`define FCM_REL_SECOND     8'h96
`define FCM_FN_READ        8'h00
`define FCM_FN_WRITE       8'h01
`define FCM_FN_UNCLAMP     8'h02
`define FCM_FN_FORMAT      8'h03
`define FCM_FN_SEEK        8'h04
`define FCM_FN_CLAMP       8'h09
`define FCM_FN_PARK        8'h0f
`define FCM_DRV_TOP        8'h00
`define FCM_DRV_OTHER      8'h80
`define FCM_SIDE_MAX       8'h01
`define FCM_TRACK_MAX      8'h2d
`define FCM_CONFIRM_VAL    8'hff
`define FCM_RETRY_NONE     8'h64
// ---------------------------------------------------------------
// error status codes
// ---------------------------------------------------------------
`define FCM_ERR_NONE       8'h00
`define FCM_ERR_CMD        8'h01
`define FCM_ERR_DRIVE      8'h02
`define FCM_ERR_SECTOR     8'h03
`define FCM_ERR_SIDE       8'h04
`define FCM_ERR_TRACK      8'h05
`define FCM_ERR_MASK       8'h06
`define FCM_ERR_NOT_EN     8'h08
`define FCM_ERR_INT_PEND   8'h09
`define FCM_ERR_CONFIRM    8'h0a
`endif

// ===== test/fcm_host_model.sv
// host processor model that reads and writes the shared command block
`timescale 1ns/1ps

module fcm_host_model (
  input  wire       clk,
  input  wire [7:0] host_rdata_reg,
  output reg  [9:0] host_addr,
  output reg        host_wr,
  output reg  [7:0] host_wdata,
  output reg        host_rd
);
  // idle bus at time zero
  initial begin
    host_addr = 10'h000;
    host_wr = 1'b0;
    host_wdata = 8'h00;
    host_rd = 1'b0;
  end
  // one byte write, data inverted once released so no stale value lingers
  task wr_byte(input [9:0] a, input [7:0] d);
    begin
      @(negedge clk);
      host_addr = a;
      host_wdata = d;
      host_wr = 1'b1;
      @(negedge clk);
      host_wr = 1'b0;
      host_wdata = ~d;
    end
  endtask
  // one byte read, data taken the cycle after the request
  task rd_byte(input [9:0] a, output [7:0] d);
    begin
      @(negedge clk);
      host_addr = a;
      host_rd = 1'b1;
      @(negedge clk);
      host_rd = 1'b0;
      d = host_rdata_reg;
    end
  endtask
  // parameters first, trigger byte last; caller posts only when ready
  task post(input [63:0] blk);
    integer i;
    begin
      for (i = 1; i < 8; i = i + 1) begin
        wr_byte(i[9:0], blk[63-8*i -: 8]);
      end
      wr_byte(10'h000, blk[63:56]);
    end
  endtask
endmodule // fcm_host_model

// ===== test/fcm_mailbox_chk.sv
// assertion checker watching the floppy command mailbox ports
`timescale 1ns/1ps
`include "fcm_regs.vh"

module fcm_mailbox_chk (
  input wire       clk,
  input wire       srst,
  input wire       host_rd,
  input wire [7:0] host_rdata_reg,
  input wire       host_locked_reg,
  input wire       disk_interrupt_request_reg,
  input wire       controller_busy_flag_reg,
  input wire [1:0] seq_phase_reg,
  input wire       op_start_reg,
  input wire       op_abort_reg,
  input wire [7:0] op_func_reg,
  input wire       op_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // ------------------------------------------------
  // handshake and sequencer relations
  // ------------------------------------------------
  lock_means_busy_a: assert property (host_locked_reg |-> !controller_busy_flag_reg)
    else $error("host locked while ready");
  lock_read_zero_a: assert property (host_rd && host_locked_reg |=> host_rdata_reg == 8'h00)
    else $error("read data leaked during lock");
  start_exec_a: assert property (op_start_reg |-> seq_phase_reg == 2'h2 && !controller_busy_flag_reg)
    else $error("operation started outside execution");
  start_pulse_a: assert property (op_start_reg |=> !op_start_reg)
    else $error("start pulse too long");
  phase_legal_a: assert property (seq_phase_reg != 2'h3)
    else $error("illegal sequencer phase");
  ready_idle_a: assert property (controller_busy_flag_reg |-> seq_phase_reg != 2'h2)
    else $error("ready while executing");
  irq_after_done_a: assert property (op_done && op_func_reg != `FCM_FN_PARK |=> disk_interrupt_request_reg)
    else $error("no interrupt after completion");
  irq_clear_busy_a: assert property ($fell(disk_interrupt_request_reg) |-> !controller_busy_flag_reg)
    else $error("interrupt dropped while idle");
  abort_halt_a: assert property (op_abort_reg |=> !controller_busy_flag_reg [*8])
    else $error("ready again after abort");
  reset_quiet_a: assert property (disable iff (1'b0) srst |=> !controller_busy_flag_reg && !op_start_reg)
    else $error("outputs active in reset");
endmodule // fcm_mailbox_chk

bind fcm_mailbox fcm_mailbox_chk fcm_mailbox_chk_i (
  .clk(clk), .srst(srst), .host_rd(host_rd), .host_rdata_reg(host_rdata_reg), .host_locked_reg(host_locked_reg),
  .disk_interrupt_request_reg(disk_interrupt_request_reg), .controller_busy_flag_reg(controller_busy_flag_reg),
  .seq_phase_reg(seq_phase_reg), .op_start_reg(op_start_reg), .op_abort_reg(op_abort_reg),
  .op_func_reg(op_func_reg), .op_done(op_done));

// ===== test/tb_floppy_command_mailbox.sv
// self-checking bench of the floppy command mailbox
`timescale 1ns/1ps
`include "fcm_regs.vh"
`define FCM_CHECK(got, exp) \
  begin \
    checks = checks + 1; \
    if ((got) !== (exp)) begin \
      failures = failures + 1; \
      $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end

module tb_floppy_command_mailbox;
  reg         clk, srst;
  reg         op_done = 1'b0;
  reg  [3:0]  eng_cnt = 4'h0;
  reg  [7:0]  eng_err;
  reg  [1:0]  disk_in;
  reg  [23:0] cap;
  reg  [7:0]  rd_val;
  reg  [79:0] rows [0:12];
  integer     checks, failures, i, n;
  wire [9:0]  host_addr;
  wire [7:0]  host_wdata, host_rdata_reg, op_func_reg, op_track_reg, op_sector_reg;
  wire [1:0]  seq_phase_reg;
  wire        host_wr, host_rd, host_locked_reg, disk_interrupt_request_reg, controller_busy_flag_reg;
  wire        op_start_reg, op_abort_reg, op_drive_reg, op_side_reg;

  fcm_mailbox fcm_mailbox_i (
    .clk(clk), .srst(srst), .host_addr(host_addr), .host_wr(host_wr), .host_wdata(host_wdata),
    .host_rd(host_rd), .host_rdata_reg(host_rdata_reg), .host_locked_reg(host_locked_reg),
    .disk_interrupt_request_reg(disk_interrupt_request_reg), .controller_busy_flag_reg(controller_busy_flag_reg),
    .seq_phase_reg(seq_phase_reg), .op_start_reg(op_start_reg), .op_abort_reg(op_abort_reg),
    .op_func_reg(op_func_reg), .op_drive_reg(op_drive_reg), .op_side_reg(op_side_reg),
    .op_track_reg(op_track_reg), .op_sector_reg(op_sector_reg), .op_done(op_done),
    .op_error(eng_err), .op_retries(8'h03), .disk_present(disk_in));
  fcm_host_model fcm_host_model_i (.clk(clk), .host_rdata_reg(host_rdata_reg), .host_addr(host_addr),
    .host_wr(host_wr), .host_wdata(host_wdata), .host_rd(host_rd));

  // clock
  always #50 clk = ~clk;
  // disk engine stand-in: finishes each operation five cycles after its start
  always @(negedge clk) begin
    op_done <= 1'b0;
    if (eng_cnt != 4'h0) begin
      eng_cnt <= eng_cnt - 4'h1;
      op_done <= (eng_cnt == 4'h1);
    end else if (op_start_reg) begin
      eng_cnt <= 4'h5;
      cap <= {op_func_reg, op_track_reg, op_sector_reg};
    end
  end

  task print_verdict;
    begin
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  // read the status byte until the ready flag is set, bounded at 3000 reads
  task wait_idle;
    begin
      n = 0;
      while (controller_busy_flag_reg !== 1'b1 && n < 3000) begin
        fcm_host_model_i.rd_byte(`FCM_OFS_ERROR, rd_val);
        n = n + 1;
      end
      if (n == 3000) begin
        failures = failures + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, controller_busy_flag_reg, 1'b1);
        print_verdict;
      end
    end
  endtask
  task issue(input [63:0] blk);
    begin
      fcm_host_model_i.post(blk);
      repeat (3) @(negedge clk);
      wait_idle;
    end
  endtask
  task run_row(input [79:0] r);
    begin
      issue(r[79:16]);
      fcm_host_model_i.rd_byte(`FCM_OFS_TRIGGER, rd_val);
      `FCM_CHECK(rd_val, 8'h00)
      fcm_host_model_i.rd_byte(`FCM_OFS_ERROR, rd_val);
      `FCM_CHECK(rd_val, r[15:8])
      `FCM_CHECK(disk_interrupt_request_reg, r[0])
    end
  endtask

  initial begin
    clk = 1'b0;
    srst = 1'b1;
    eng_err = 8'h00;
    disk_in = 2'b00;
    checks = 0;
    failures = 0;
    // trigger, mask or function, drive, side, sector, track, speed, confirm, error, interrupt
    rows[0] = 80'h86_03_00_00_00_00_00_ff_00_00;
    rows[1] = 80'h86_03_80_00_00_00_00_ff_00_00;
    rows[2] = 80'h81_00_00_00_14_05_00_ff_00_01;
    rows[3] = 80'h85_01_00_00_00_00_00_ff_00_00;
    rows[4] = 80'h81_00_00_02_00_00_00_ff_04_00;
    rows[5] = 80'h81_00_00_00_00_2e_00_ff_05_00;
    rows[6] = 80'h81_00_01_00_00_00_00_ff_02_00;
    rows[7] = 80'h81_00_00_00_16_00_00_ff_03_00;
    rows[8] = 80'h81_03_00_00_00_00_00_00_0a_00;
    rows[9] = 80'h84_00_00_00_00_00_00_ff_01_00;
    rows[10] = 80'h57_02_80_00_00_00_00_ff_00_00;
    rows[11] = 80'h81_09_80_00_00_00_00_ff_08_00;
    rows[12] = 80'h85_00_00_00_00_00_00_ff_06_00;
    repeat (5) @(negedge clk);
    `FCM_CHECK({controller_busy_flag_reg, host_locked_reg, disk_interrupt_request_reg}, 3'h0)
    srst = 1'b0;
    wait_idle;
    for (i = 0; i < 13; i = i + 1) begin
      run_row(rows[i]);
      if (i == 2) begin
        fcm_host_model_i.rd_byte(`FCM_OFS_RETRY, rd_val);
        `FCM_CHECK(rd_val, 8'h03)
        `FCM_CHECK(cap, 24'h00_05_14)
      end
    end
    $display("test rows done");
    // a pending interrupt refuses drive enable until the clear command runs
    issue(64'h81_00_00_00_00_00_00_ff);
    issue(64'h86_03_00_00_00_00_00_ff);
    fcm_host_model_i.rd_byte(`FCM_OFS_ERROR, rd_val);
    `FCM_CHECK(rd_val, 8'h09)
    fcm_host_model_i.rd_byte(`FCM_OFS_TRIGGER, rd_val);
    `FCM_CHECK(rd_val, 8'h00)
    fcm_host_model_i.wr_byte(`FCM_OFS_TRIGGER, 8'h00);
    run_row(80'h85_01_00_00_00_00_00_ff_00_00);
    $display("test pending done");
    // engine error reaches the status byte; a disk inserted in an enabled drive raises the interrupt
    eng_err = 8'h17;
    run_row(80'h81_00_00_00_00_00_00_ff_17_01);
    eng_err = 8'h00;
    run_row(80'h85_01_00_00_00_00_00_ff_00_00);
    disk_in = 2'b01;
    repeat (6) @(negedge clk);
    `FCM_CHECK(disk_interrupt_request_reg, 1'b1)
    run_row(80'h85_01_00_00_00_00_00_ff_00_00);
    $display("test engine done");
    // parked wait, release sequence, cold start sweep
    fcm_host_model_i.wr_byte(10'h3ff, 8'h5a);
    fcm_host_model_i.rd_byte(10'h3ff, rd_val);
    `FCM_CHECK(rd_val, 8'h5a)
    fcm_host_model_i.wr_byte(10'h180, 8'ha5);
    fcm_host_model_i.post(64'h88_00_00_00_00_00_00_ff);
    rd_val = 8'hff;
    n = 0;
    while (rd_val !== 8'h00 && n < 500) begin
      fcm_host_model_i.rd_byte(`FCM_OFS_TRIGGER, rd_val);
      n = n + 1;
    end
    `FCM_CHECK(rd_val, 8'h00)
    if (rd_val !== 8'h00) print_verdict;
    `FCM_CHECK(cap[23:16], `FCM_FN_PARK)
    repeat (3) @(negedge clk);
    `FCM_CHECK(controller_busy_flag_reg, 1'b0)
    fcm_host_model_i.wr_byte(`FCM_OFS_TRIGGER, 8'h69);
    fcm_host_model_i.wr_byte(`FCM_OFS_TRIGGER, 8'h96);
    repeat (3) @(negedge clk);
    wait_idle;
    fcm_host_model_i.rd_byte(10'h3ff, rd_val);
    `FCM_CHECK(rd_val, 8'h00)
    fcm_host_model_i.rd_byte(10'h180, rd_val);
    `FCM_CHECK(rd_val, 8'ha5)
    $display("test rom wait done");
    // go away halts until the next reset
    fcm_host_model_i.post(64'h89_00_00_00_00_00_00_ff);
    repeat (40) @(negedge clk);
    `FCM_CHECK(controller_busy_flag_reg, 1'b0)
    srst = 1'b1;
    repeat (5) @(negedge clk);
    `FCM_CHECK({controller_busy_flag_reg, host_locked_reg, disk_interrupt_request_reg}, 3'h0)
    srst = 1'b0;
    wait_idle;
    fcm_host_model_i.rd_byte(`FCM_OFS_ERROR, rd_val);
    `FCM_CHECK(rd_val, 8'h00)
    $display("test go away done");
    print_verdict;
  end
endmodule // tb_floppy_command_mailbox
